// [pkg/sbc_pkg.sv]
// Constants and state codes for the mode sequencer
package sbc_pkg;

    localparam int unsigned CLK_HZ    = 20_000_000;
    localparam int unsigned CNT_W     = 24;

    // Times in their own units
    localparam int unsigned T_NREQ_MS = 350;
    localparam int unsigned T_VLOW_MS = 100;
    localparam int unsigned T_RST_MS  = 1;
    localparam int unsigned T_WD0_MS  = 10;
    localparam int unsigned T_WD1_MS  = 50;
    localparam int unsigned T_WD2_MS  = 150;
    localparam int unsigned T_WD3_MS  = 350;

    function automatic int unsigned ms_to_cyc(input int unsigned ms);
        return 32'((64'(ms) * 64'(CLK_HZ)) / 64'd1000);
    endfunction : ms_to_cyc

    localparam int unsigned NREQ_CYC = ms_to_cyc(T_NREQ_MS);
    localparam int unsigned VLOW_CYC = ms_to_cyc(T_VLOW_MS);
    localparam int unsigned RST_CYC  = ms_to_cyc(T_RST_MS);
    localparam int unsigned WD0_CYC  = ms_to_cyc(T_WD0_MS);
    localparam int unsigned WD1_CYC  = ms_to_cyc(T_WD1_MS);
    localparam int unsigned WD2_CYC  = ms_to_cyc(T_WD2_MS);
    localparam int unsigned WD3_CYC  = ms_to_cyc(T_WD3_MS);

    // Mode control data field
    localparam logic [3:0] MCR_DEBUG   = 4'h0;
    localparam logic [2:0] MCR_NORMAL  = 3'h5;
    localparam logic [2:0] MCR_STANDBY = 3'h6;
    localparam logic [2:0] MCR_STOP    = 3'h2;
    localparam logic [2:0] MCR_SLEEP   = 3'h3;

    typedef enum logic [5:0] {
        ST_RESET   = 6'h01,
        ST_NREQ    = 6'h02,
        ST_NORMAL  = 6'h04,
        ST_STANDBY = 6'h08,
        ST_STOP    = 6'h10,
        ST_SLEEP   = 6'h20
    } state_t;

endpackage : sbc_pkg

// [pkg/watchdog_fail_output_if.sv]
// Link between the sequencer and its watchdog timer
`timescale 1ns/1ns
`default_nettype none
interface watchdog_fail_output_if;
    logic                      en;
    logic                      window_mode;
    logic                      stop_mode;
    logic                      kick;
    logic [sbc_pkg::CNT_W-1:0] period;
    logic                      expire;

    modport ctrl (output en, output window_mode, output stop_mode, output kick,
                  output period, input expire);
    modport wdt  (input en, input window_mode, input stop_mode, input kick,
                  input period, output expire);
endinterface : watchdog_fail_output_if
`default_nettype wire

// [verilog/watchdog_fail_output_timer.sv]
// Watchdog period counter with closed and open window
`timescale 1ns/1ns
`default_nettype none
module watchdog_fail_output_timer (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // Control
    watchdog_fail_output_if.wdt       w
);
    logic [sbc_pkg::CNT_W-1:0] cnt_r;
    logic                      expire_r;
    wire                       closed   = cnt_r < (w.period >> 1);
    wire                       bad_kick = w.kick & w.window_mode & ~w.stop_mode & closed;
    wire                       run_out  = cnt_r >= w.period - 1'b1;

    assign w.expire = expire_r;

    always_ff @(posedge core_clk) begin
        if (!rstn || !w.en) begin
            cnt_r    <= '0;
            expire_r <= 1'b0;
        end else begin
            expire_r <= bad_kick | (run_out & ~w.kick);
            cnt_r    <= (w.kick || run_out) ? '0 : cnt_r + 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    period_run_a : assert property (w.en && run_out && !w.kick |=> w.expire)
        else $error("watchdog did not expire at end of period");
    closed_kick_a : assert property (w.en && bad_kick |=> w.expire)
        else $error("kick in closed window not punished");
    open_kick_a : assert property (w.en && w.kick && !bad_kick |=> !w.expire && cnt_r == '0)
        else $error("good kick did not restart watchdog");
endmodule : watchdog_fail_output_timer
`default_nettype wire

// [verilog/sbc_mode_sequencer.sv]
// Operating mode sequencer with periodic reset, watchdog and debug modes
//
// Notes on behaviour
// - Power-up and sleep wake pass through reset
// - Flag bits are true when they read one
// - Supply low beyond long time raises condition
// - Any timing register write triggers watchdog
// - Missed or badly placed trigger is timeout
// - Normal request lasts the long timeout
// - Mode writes request sleep, stop, normal, standby
// - Unconfigured device resets every long period
// - Reset low, then high, repeating periodically
// - Power-up sets supply loss, allows request
// - Writing zero after trigger arms debug
// - Normal debug code then enters debug
// - Debug modes never clear nor reset watchdog
// - Writing zero in debug leaves debug
// - Entry writes must fit request window
// - Debug wake goes to request for window
// - Stop from debug runs without watchdog
// - Supply low still forces reset in debug
// - Closed window trigger causes reset, except in stop
// - Fail output low until proper trigger
`timescale 1ns/1ns
`default_nettype none
module sbc_mode_sequencer #(
    parameter int unsigned NREQ_CYC = sbc_pkg::NREQ_CYC,
    parameter int unsigned VLOW_CYC = sbc_pkg::VLOW_CYC,
    parameter int unsigned RST_CYC  = sbc_pkg::RST_CYC,
    parameter int unsigned WD0_CYC  = sbc_pkg::WD0_CYC,
    parameter int unsigned WD1_CYC  = sbc_pkg::WD1_CYC,
    parameter int unsigned WD2_CYC  = sbc_pkg::WD2_CYC,
    parameter int unsigned WD3_CYC  = sbc_pkg::WD3_CYC
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Decoded serial port accesses
    input  wire logic       mcr_wr,
    input  wire logic [3:0] mcr_data,
    input  wire logic       mcr_rd,
    input  wire logic       watchdog_timing_subreg_wr,
    input  wire logic       wd_window_sel,
    input  wire logic [1:0] wd_period_sel,
    input  wire logic       stop_watchdog_enable,
    input  wire logic       stop_inhibit_flag,
    // Supply monitors and wake
    input  wire logic       vdd_low,
    input  wire logic       vdd_overtemp,
    input  wire logic       wake_event,
    // Outputs
    output logic            rst_out_n,
    output logic            watchdog_fail_output_n,
    output logic [5:0]      mode,
    output logic            debug_active,
    output logic            supply_loss_flag,
    output logic            vdd_low_long
);
    localparam int unsigned W = sbc_pkg::CNT_W;

    if (NREQ_CYC < 2 || VLOW_CYC < 2 || RST_CYC < 2 || WD0_CYC < 2 || WD1_CYC < 2
        || WD2_CYC < 2 || WD3_CYC < 2)
        $error("sequencer counts must be at least 2");
    if (NREQ_CYC >= 2**W || VLOW_CYC >= 2**W || RST_CYC >= 2**W || WD0_CYC >= 2**W
        || WD1_CYC >= 2**W || WD2_CYC >= 2**W || WD3_CYC >= 2**W)
        $error("sequencer counts exceed counter width");

    sbc_pkg::state_t state_r, state_nxt;
    logic [W-1:0]    cnt_r;
    logic [W-1:0]    seq_cnt_r;
    logic [W-1:0]    vlow_cnt_r;
    logic            rst_out_n_r;
    logic            wd_fail_n_r;
    logic            dbg_r;
    logic            dbg_arm_r;
    logic            loss_r;
    logic            vlow_long_r;
    logic            configured_r;

    watchdog_fail_output_if wif ();

    watchdog_fail_output_timer u_watchdog_fail_output (
        .core_clk (core_clk),
        .rstn     (rstn),
        .w        (wif.wdt)
    );

    function automatic logic [W-1:0] wd_period(input logic [1:0] sel);
        unique case (sel)
            2'h0:    return W'(WD0_CYC);
            2'h1:    return W'(WD1_CYC);
            2'h2:    return W'(WD2_CYC);
            default: return W'(WD3_CYC);
        endcase
    endfunction : wd_period

    // Decoded states and mode writes
    wire in_reset   = state_r == sbc_pkg::ST_RESET;
    wire in_nreq    = state_r == sbc_pkg::ST_NREQ;
    wire in_normal  = state_r == sbc_pkg::ST_NORMAL;
    wire in_standby = state_r == sbc_pkg::ST_STANDBY;
    wire in_stop    = state_r == sbc_pkg::ST_STOP;
    wire in_sleep   = state_r == sbc_pkg::ST_SLEEP;
    wire wr_zero    = mcr_wr && mcr_data == sbc_pkg::MCR_DEBUG;
    wire wr_normal  = mcr_wr && mcr_data[2:0] == sbc_pkg::MCR_NORMAL;
    wire wr_standby = mcr_wr && mcr_data[2:0] == sbc_pkg::MCR_STANDBY;
    wire wr_stop    = mcr_wr && mcr_data[2:0] == sbc_pkg::MCR_STOP;
    wire wr_sleep   = mcr_wr && mcr_data[2:0] == sbc_pkg::MCR_SLEEP;

    // Conditions
    wire rst_done   = cnt_r >= W'(RST_CYC - 1);
    wire nreq_out   = cnt_r >= W'(NREQ_CYC - 1);
    wire seq_open   = seq_cnt_r < W'(NREQ_CYC);
    wire vlow_long  = vlow_cnt_r >= W'(VLOW_CYC);
    wire inhibit    = stop_inhibit_flag == 1'b1;
    wire loss_set   = loss_r == 1'b1;
    wire wd_timeout = wif.expire;
    wire arm_ok     = in_normal && !dbg_r && loss_set && seq_open;
    wire dbg_enter  = dbg_arm_r && wr_normal && seq_open;
    wire dbg_leave  = dbg_r && wr_zero;

    // Watchdog only in normal, standby and, if enabled, stop; never in debug
    assign wif.en          = (in_normal || in_standby || (in_stop && stop_watchdog_enable))
                             && !dbg_r;
    assign wif.window_mode = wd_window_sel;
    assign wif.stop_mode   = in_stop;
    assign wif.kick        = watchdog_timing_subreg_wr;
    assign wif.period      = wd_period(wd_period_sel);

    // Priority: supply low, overtemperature, timeouts, then serial commands
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sbc_pkg::ST_RESET: begin
                if (vlow_long && !inhibit)
                    state_nxt = sbc_pkg::ST_SLEEP;
                else if (!vdd_low && rst_done && (loss_set || configured_r))
                    state_nxt = sbc_pkg::ST_NREQ;
            end
            sbc_pkg::ST_NREQ: begin
                if (vdd_low)
                    state_nxt = sbc_pkg::ST_RESET;
                else if (vdd_overtemp)
                    state_nxt = sbc_pkg::ST_SLEEP;
                else if (nreq_out)
                    state_nxt = sbc_pkg::ST_RESET;
                else if (watchdog_timing_subreg_wr || wr_normal)
                    state_nxt = sbc_pkg::ST_NORMAL;
                else if (wr_standby)
                    state_nxt = sbc_pkg::ST_STANDBY;
            end
            sbc_pkg::ST_NORMAL,
            sbc_pkg::ST_STANDBY: begin
                if (vdd_low)
                    state_nxt = sbc_pkg::ST_RESET;
                else if (vdd_overtemp)
                    state_nxt = sbc_pkg::ST_SLEEP;
                else if (wd_timeout)
                    state_nxt = sbc_pkg::ST_RESET;
                else if (wr_sleep)
                    state_nxt = sbc_pkg::ST_SLEEP;
                else if (wr_stop)
                    state_nxt = sbc_pkg::ST_STOP;
                else if (wr_normal)
                    state_nxt = sbc_pkg::ST_NORMAL;
                else if (wr_standby)
                    state_nxt = sbc_pkg::ST_STANDBY;
            end
            sbc_pkg::ST_STOP: begin
                if (vdd_low)
                    state_nxt = sbc_pkg::ST_RESET;
                else if (wd_timeout)
                    state_nxt = sbc_pkg::ST_RESET;
                else if (wake_event)
                    state_nxt = sbc_pkg::ST_NREQ;
            end
            sbc_pkg::ST_SLEEP: begin
                if (wake_event)
                    state_nxt = sbc_pkg::ST_RESET;
            end
            default: state_nxt = sbc_pkg::ST_RESET;
        endcase
    end

    // Mode timer restarts on every state change
    always_ff @(posedge core_clk) begin
        if (!rstn || state_nxt != state_r)
            cnt_r <= '0;
        else if (!(&cnt_r))
            cnt_r <= cnt_r + 1'b1;
    end

    // Debug entry window runs from request entry through normal
    always_ff @(posedge core_clk) begin
        if (!rstn || in_reset || in_sleep || in_stop)
            seq_cnt_r <= '0;
        else if (seq_open)
            seq_cnt_r <= seq_cnt_r + 1'b1;
    end

    // Time spent below the reset threshold
    always_ff @(posedge core_clk) begin
        if (!rstn || !vdd_low)
            vlow_cnt_r <= '0;
        else if (!vlow_long)
            vlow_cnt_r <= vlow_cnt_r + 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_r     <= sbc_pkg::ST_RESET;
            rst_out_n_r <= 1'b0;
            vlow_long_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            rst_out_n_r <= state_nxt != sbc_pkg::ST_RESET;
            vlow_long_r <= vlow_long;
        end
    end

    // Fail output: timeout sets, proper trigger clears, set wins
    always_ff @(posedge core_clk) begin
        if (!rstn)
            wd_fail_n_r <= 1'b0;
        else if (wd_timeout || (in_nreq && nreq_out && !vdd_low && !vdd_overtemp))
            wd_fail_n_r <= 1'b0;
        else if (watchdog_timing_subreg_wr)
            wd_fail_n_r <= 1'b1;
    end

    // Supply loss flag: set by power-up, cleared by a mode read
    always_ff @(posedge core_clk) begin
        if (!rstn)
            loss_r <= 1'b1;
        else if (mcr_rd)
            loss_r <= 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn)
            configured_r <= 1'b0;
        else if (watchdog_timing_subreg_wr)
            configured_r <= 1'b1;
    end

    // Debug arming and debug state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dbg_arm_r <= 1'b0;
            dbg_r     <= 1'b0;
        end else begin
            if (!in_normal || dbg_enter || (mcr_wr && !wr_zero))
                dbg_arm_r <= 1'b0;
            else if (wr_zero && arm_ok)
                dbg_arm_r <= 1'b1;
            if (dbg_leave)
                dbg_r <= 1'b0;
            else if (dbg_enter)
                dbg_r <= 1'b1;
        end
    end

    assign rst_out_n              = rst_out_n_r;
    assign watchdog_fail_output_n = wd_fail_n_r;
    assign mode                   = state_r;
    assign debug_active           = dbg_r;
    assign supply_loss_flag       = loss_r;
    assign vdd_low_long           = vlow_long_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    reset_first_a : assert property ($rose(in_nreq) |-> $past(in_reset) || $past(in_stop))
        else $error("request entered without reset or stop wake");
    sleep_wake_a : assert property (in_sleep && wake_event |=> in_reset)
        else $error("sleep wake skipped reset");
    flag_long_a : assert property (in_reset && vlow_long && !stop_inhibit_flag |=> in_sleep)
        else $error("long supply loss not acted on");
    vlow_time_a : assert property (!vdd_low |=> ##1 !vdd_low_long)
        else $error("long supply condition without supply low");
    nreq_time_a : assert property (in_nreq && nreq_out && !vdd_low && !vdd_overtemp
                                   |=> in_reset && !watchdog_fail_output_n)
        else $error("request timeout not applied");
    rst_pin_a : assert property (in_reset == !rst_out_n)
        else $error("reset output does not follow reset mode");
    fail_clear_a : assert property (watchdog_timing_subreg_wr && !wd_timeout && !(in_nreq && nreq_out)
                                    |=> watchdog_fail_output_n)
        else $error("fail output not released by trigger");
    debug_nowd_a : assert property (dbg_r |-> !wif.en)
        else $error("watchdog running in debug");
    debug_exit_a : assert property (dbg_leave |=> !debug_active)
        else $error("debug not left on zero write");
    debug_supply_a : assert property (dbg_r && vdd_low && !in_sleep && !in_reset
                                      |=> in_reset)
        else $error("supply low ignored in debug");
    debug_enter_a : assert property (dbg_arm_r && wr_normal && seq_open && !dbg_r
                                     |=> debug_active)
        else $error("debug not entered");
endmodule : sbc_mode_sequencer
`default_nettype wire

// [tb/mcu_model.sv]
// Controller model issuing decoded serial accesses to the sequencer
`timescale 1ns/1ns
`default_nettype none
module mcu_model #(
    parameter int DLY = 5
) (
    // Clock
    input  wire logic  core_clk,
    // Decoded serial accesses
    output logic       mcr_wr,
    output logic [3:0] mcr_data,
    output logic       mcr_rd,
    output logic       watchdog_timing_subreg_wr
);
    initial begin
        mcr_wr   = 1'b0;
        mcr_data = 4'h0;
        mcr_rd   = 1'b0;
        watchdog_timing_subreg_wr  = 1'b0;
    end

    // Data is inverted after the write so a stale value differs from the one written
    task automatic write_mcr(input logic [3:0] d);
        @(posedge core_clk);
        #DLY;
        mcr_wr   = 1'b1;
        mcr_data = d;
        @(posedge core_clk);
        #DLY;
        mcr_wr   = 1'b0;
        mcr_data = ~d;
    endtask : write_mcr

    task automatic write_watchdog_timing_subreg();
        @(posedge core_clk);
        #DLY;
        watchdog_timing_subreg_wr = 1'b1;
        @(posedge core_clk);
        #DLY;
        watchdog_timing_subreg_wr = 1'b0;
    endtask : write_watchdog_timing_subreg

    task automatic read_mcr();
        @(posedge core_clk);
        #DLY;
        mcr_rd = 1'b1;
        @(posedge core_clk);
        #DLY;
        mcr_rd = 1'b0;
    endtask : read_mcr

    // Three entry writes, one idle cycle apart, inside the request window
    task automatic enter_debug();
        write_watchdog_timing_subreg();
        write_mcr(4'h0);
        write_mcr(4'h5);
    endtask : enter_debug
endmodule : mcu_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the mode sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    localparam int DLY = 5;
    localparam int NREQ = 40;
    localparam int VLOW = 20;
    localparam int RST = 8;
    localparam int WD0 = 16;
    localparam int WD3 = 40;
    typedef struct {logic [1:0] act; logic [3:0] data; logic [5:0] exp_mode;} row_t;

    logic       core_clk = 1'b0;
    logic       rstn;
    logic       mcr_wr, mcr_rd, watchdog_timing_subreg_wr;
    logic [3:0] mcr_data;
    logic       wd_window_sel, stop_watchdog_enable, stop_inhibit_flag;
    logic [1:0] wd_period_sel;
    logic       vdd_low, vdd_overtemp, wake_event;
    logic       rst_out_n, watchdog_fail_output_n, debug_active;
    logic       supply_loss_flag, vdd_low_long;
    logic [5:0] mode;
    int         err_count = 0;
    int         n_checks = 0;
    int         n;
    // Action 0 mode write, 1 trigger, 2 wake, 3 overtemp
    row_t rows [12] = '{'{2'h0, 4'h6, 6'h08}, '{2'h0, 4'hd, 6'h04}, '{2'h0, 4'h2, 6'h10},
                        '{2'h2, 4'h0, 6'h02}, '{2'h1, 4'h0, 6'h04}, '{2'h0, 4'h3, 6'h20},
                        '{2'h2, 4'h0, 6'h02}, '{2'h1, 4'h0, 6'h04}, '{2'h0, 4'he, 6'h08},
                        '{2'h3, 4'h0, 6'h20}, '{2'h2, 4'h0, 6'h02}, '{2'h1, 4'h0, 6'h04}};

    always #25 core_clk = ~core_clk;

    sbc_mode_sequencer #(.NREQ_CYC(NREQ), .VLOW_CYC(VLOW), .RST_CYC(RST), .WD0_CYC(WD0),
        .WD1_CYC(20), .WD2_CYC(24), .WD3_CYC(WD3)) dut (
        .core_clk(core_clk), .rstn(rstn), .mcr_wr(mcr_wr), .mcr_data(mcr_data),
        .mcr_rd(mcr_rd), .watchdog_timing_subreg_wr(watchdog_timing_subreg_wr), .wd_window_sel(wd_window_sel),
        .wd_period_sel(wd_period_sel), .stop_watchdog_enable(stop_watchdog_enable),
        .stop_inhibit_flag(stop_inhibit_flag), .vdd_low(vdd_low),
        .vdd_overtemp(vdd_overtemp), .wake_event(wake_event), .rst_out_n(rst_out_n),
        .watchdog_fail_output_n(watchdog_fail_output_n), .mode(mode),
        .debug_active(debug_active), .supply_loss_flag(supply_loss_flag),
        .vdd_low_long(vdd_low_long));

    mcu_model #(.DLY(DLY)) u_mcu (.core_clk(core_clk), .mcr_wr(mcr_wr),
        .mcr_data(mcr_data), .mcr_rd(mcr_rd), .watchdog_timing_subreg_wr(watchdog_timing_subreg_wr));

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #DLY;
    endtask : cyc

    // Bounded wait; the count lets callers check how long a mode lasted
    task automatic wait_mode(input logic [5:0] e, input int lim, output int k);
        k = 0;
        while (mode !== e && k < lim) begin
            cyc(1);
            k++;
        end
        `CHK("mode", e, mode)
    endtask : wait_mode

    task automatic do_reset();
        rstn = 1'b0;
        cyc(8);
        `CHK("reset_mode", 6'h01, mode)
        `CHK("reset_out", 1'b0, rst_out_n)
        `CHK("loss_flag", 1'b1, supply_loss_flag)
        `CHK("debug_rst", 1'b0, debug_active)
        `CHK("long_rst", 1'b0, vdd_low_long)
        rstn = 1'b1;
        wait_mode(6'h02, RST + 6, n);
        `CHK("reset_len", 1'b1, n >= RST - 2)
        `CHK("reset_out_hi", 1'b1, rst_out_n)
    endtask : do_reset

    task automatic drive_lvl(input logic [1:0] a);
        cyc(1);
        wake_event   = (a == 2'h2);
        vdd_overtemp = (a == 2'h3);
        cyc(1);
        wake_event   = 1'b0;
        vdd_overtemp = 1'b0;
    endtask : drive_lvl

    task automatic end_test(input string nm);
        $display("test %s done, mismatches so far %0d", nm, err_count);
    endtask : end_test

    initial begin
        #(50 * 20000);
        err_count++;
        final_report();
    end

    initial begin
        rstn = 1'b0;
        wd_window_sel = 1'b0;
        wd_period_sel = 2'h3;
        stop_watchdog_enable = 1'b0;
        stop_inhibit_flag = 1'b0;
        vdd_low = 1'b0;
        vdd_overtemp = 1'b0;
        wake_event = 1'b0;
        do_reset();
        end_test("power_up");
        wait_mode(6'h01, NREQ + 6, n);
        `CHK("request_len", 1'b1, n >= NREQ - 3)
        `CHK("fail_unconf", 1'b0, watchdog_fail_output_n)
        `CHK("rst_unconf", 1'b0, rst_out_n)
        wait_mode(6'h02, RST + 6, n);
        u_mcu.write_watchdog_timing_subreg();
        wait_mode(6'h04, 2, n);
        `CHK("fail_cleared", 1'b1, watchdog_fail_output_n)
        end_test("unconfigured");
        foreach (rows[i]) begin
            case (rows[i].act)
                2'h0: u_mcu.write_mcr(rows[i].data);
                2'h1: u_mcu.write_watchdog_timing_subreg();
                default: drive_lvl(rows[i].act);
            endcase
            wait_mode(rows[i].exp_mode, RST + 20, n);
        end
        end_test("mode_table");
        wd_period_sel = 2'h0;
        wait_mode(6'h01, WD0 + 6, n);
        `CHK("fail_timeout", 1'b0, watchdog_fail_output_n)
        wait_mode(6'h02, RST + 6, n);
        `CHK("fail_held", 1'b0, watchdog_fail_output_n)
        u_mcu.write_watchdog_timing_subreg();
        wait_mode(6'h04, 2, n);
        `CHK("fail_release", 1'b1, watchdog_fail_output_n)
        end_test("timeout");
        wd_window_sel = 1'b1;
        u_mcu.write_watchdog_timing_subreg();
        wait_mode(6'h01, 4, n);
        wait_mode(6'h02, RST + 6, n);
        u_mcu.write_watchdog_timing_subreg();
        cyc(12);
        u_mcu.write_watchdog_timing_subreg();
        cyc(4);
        `CHK("open_window", 6'h04, mode)
        wd_window_sel = 1'b0;
        wd_period_sel = 2'h3;
        end_test("window");
        fork
            u_mcu.write_watchdog_timing_subreg();
            begin
                cyc(1);
                vdd_low = 1'b1;
            end
        join
        wait_mode(6'h01, 2, n);
        stop_inhibit_flag = 1'b1;
        cyc(VLOW - 4);
        `CHK("long_early", 1'b0, vdd_low_long)
        cyc(8);
        `CHK("long_set", 1'b1, vdd_low_long)
        `CHK("inhibit_hold", 6'h01, mode)
        // Supply must recover before the inhibit drops, or the stale long flag sends it to sleep
        vdd_low = 1'b0;
        cyc(1);
        stop_inhibit_flag = 1'b0;
        wait_mode(6'h02, RST + 6, n);
        end_test("supply_low");
        do_reset();
        u_mcu.read_mcr();
        `CHK("loss_clear", 1'b0, supply_loss_flag)
        u_mcu.enter_debug();
        cyc(2);
        `CHK("no_debug", 1'b0, debug_active)
        end_test("debug_refused");
        do_reset();
        u_mcu.enter_debug();
        cyc(2);
        `CHK("debug_on", 1'b1, debug_active)
        `CHK("debug_mode", 6'h04, mode)
        wd_period_sel = 2'h0;
        cyc(WD0 * 4);
        `CHK("debug_no_wd", 6'h04, mode)
        `CHK("debug_fail", 1'b1, watchdog_fail_output_n)
        stop_watchdog_enable = 1'b1;
        u_mcu.write_mcr(4'h2);
        wait_mode(6'h10, 3, n);
        cyc(WD3 * 2);
        `CHK("stop_no_wd", 6'h10, mode)
        drive_lvl(2'h2);
        wait_mode(6'h02, 4, n);
        u_mcu.write_mcr(4'h5);
        wait_mode(6'h04, 3, n);
        vdd_low = 1'b1;
        wait_mode(6'h01, 3, n);
        vdd_low = 1'b0;
        wait_mode(6'h02, RST + 6, n);
        u_mcu.write_mcr(4'h5);
        wait_mode(6'h04, 3, n);
        u_mcu.write_mcr(4'h0);
        cyc(1);
        `CHK("debug_off", 1'b0, debug_active)
        wait_mode(6'h01, WD0 + 6, n);
        end_test("debug");
        // Outside debug the enabled stop watchdog still times out
        wait_mode(6'h02, RST + 6, n);
        u_mcu.write_watchdog_timing_subreg();
        wait_mode(6'h04, 2, n);
        wd_period_sel = 2'h1;
        u_mcu.write_mcr(4'h2);
        wait_mode(6'h10, 3, n);
        wait_mode(6'h01, 20 + 6, n);
        `CHK("stop_wd_fail", 1'b0, watchdog_fail_output_n)
        end_test("stop_watchdog");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
